// ### inc/cisf_pkg.sv
// cisf_pkg: constants and carriers for the CAN event/condition flag block.
// assumes the SPI engine decodes opcodes and hands over one byte per access.
package cisf_pkg;

  // host opcodes
  localparam logic [7:0] OP_RD_EVENTS   = 8'hDE;
  localparam logic [7:0] OP_WR_EV_EN    = 8'h1C;
  localparam logic [7:0] OP_RD_EV_EN    = 8'hE4;
  localparam logic [7:0] OP_RD_COND     = 8'hE2;
  localparam logic [7:0] OP_WR_COND_EN  = 8'h1E;
  localparam logic [7:0] OP_RD_COND_EN  = 8'hE6;
  localparam logic [7:0] OP_WR_AUX_SEL  = 8'h22;
  localparam logic [7:0] OP_RD_AUX_SEL  = 8'hE8;
  localparam logic [7:0] OP_RD_ERROR    = 8'hDC;

  // event flag positions
  localparam int EV_RX_STAGING = 7;
  localparam int EV_RX_ACCEPT  = 6;
  localparam int EV_TX_DONE    = 5;
  localparam int EV_BUS_FAULT  = 4;
  localparam int EV_MODE       = 3;
  localparam int EV_WAKE       = 2;
  localparam int EV_FILTER1    = 1;
  localparam int EV_FILTER0    = 0;

  // condition flag positions
  localparam int CF_TX_EMPTY  = 7;
  localparam int CF_TX_FULL   = 6;
  localparam int CF_HIST_FULL = 5;
  localparam int CF_ERR_WARN  = 4;
  localparam int CF_ERR_PASS  = 3;
  localparam int CF_BUS_OFF   = 2;
  localparam int CF_RX_EMPTY  = 1;
  localparam int CF_RX_FULL   = 0;

  // reset values
  localparam logic [7:0] EV_FLAGS_RST = 8'h00;
  localparam logic [7:0] EV_EN_RST    = 8'h00;
  localparam logic [7:0] COND_RST     = 8'h82;
  localparam logic [7:0] COND_EN_RST  = 8'h00;
  localparam logic [7:0] AUX_SEL_RST  = 8'h00;
  localparam logic [3:0] FILT_NONE    = 4'h0;
  localparam logic [2:0] MODE_RST     = 3'h0;

  // error-warning window on either error counter
  localparam logic [7:0] WARN_LO = 8'h60;
  localparam logic [7:0] WARN_HI = 8'h7F;

  typedef enum logic [1:0] {
    CISF_RUN   = 2'b01,
    CISF_DRAIN = 2'b10
  } cisf_mode_e;

  // one-cycle event pulses from the protocol engine
  typedef struct packed {
    logic       rx_staging;
    logic       rx_accept;
    logic [2:0] hit_idx;
    logic       tx_done;
    logic [4:0] err_cause;
    logic       bus_wake;
  } cisf_event_s;

  // level conditions from FIFOs and error counters
  typedef struct packed {
    logic       tx_empty;
    logic       tx_full;
    logic       hist_full;
    logic       err_passive;
    logic       bus_off;
    logic       rx_empty;
    logic       rx_full;
    logic [7:0] tec;
    logic [7:0] rec;
  } cisf_cond_s;

endpackage

// ### logic/cisf_core.sv
// cisf_core: latched event flags, self-clearing condition flags, pins.
// assumes opcode accesses arrive one per cycle, already decoded from SPI.
`timescale 1ns/10ps

// Function
// - enabled event flag latches interrupt pin high
// - event flag read returns then clears all
// - bit7 set on frame in staging buffer
// - bit6 set on filtered frame into FIFO
// - bit5 set on successful transmit
// - bit4 on bus error, cause kept
// - bit3 on mode change after TX drain
// - bit2 set on wake from bus activity
// - bit1 on filter one, code 1001
// - bit0 on filter zero, code 1000
// - event enable register, opcodes 1C/E4
// - condition flag read changes nothing
// - condition flags track their conditions
// - enabled condition rise pulses status pin
// - bit7 transmit queue empty, resets one
// - bit6 transmit queue full, resets zero
// - bit5 transmit history queue full
// - bit4 when either counter 96..127
// - bit3 error passive, bit2 bus off
// - bit1 receive queue empty, resets one
// - bit0 receive queue full, resets zero
// - any flag mirrored on either aux pin
// - condition enable register, opcodes 1E/E6
// - nibble selectors: events 0-7, conditions 8-15
module cisf_core (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic               cmd_valid,
  input  wire logic               cmd_write,
  input  wire logic [7:0]         cmd_op,
  input  wire logic [7:0]         cmd_wdata,
  output logic                    rsp_valid,
  output logic [7:0]              rsp_rdata,
  input  wire cisf_pkg::cisf_event_s ev,
  input  wire cisf_pkg::cisf_cond_s  cnd,
  input  wire logic               mode_req_valid,
  input  wire logic [2:0]         mode_req,
  output logic [2:0]              cur_mode,
  output logic [3:0]              filter_match_code,
  output logic                    int_pin,
  output logic                    stat_pin,
  output logic                    aux_out_pin_a,
  output logic                    aux_out_pin_b
);

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic in_warn(input logic [7:0] cnt);
    in_warn = (cnt >= cisf_pkg::WARN_LO) && (cnt <= cisf_pkg::WARN_HI);
  endfunction

  function automatic logic pick(input logic [3:0] sel, input logic [7:0] evf,
                                input logic [7:0] cf);
    pick = sel[3] ? cf[sel[2:0]] : evf[sel[2:0]];
  endfunction

  logic [7:0] event_flags;
  logic [7:0] event_enables;
  logic [7:0] condition_flags;
  logic [7:0] condition_flag_enables;
  logic [7:0] aux_pin_select;
  logic [4:0] err_cause;
  logic [2:0] pend_mode;
  cisf_pkg::cisf_mode_e mode_state;

  logic       rd_ev;
  logic       rd_err;
  logic       mode_apply;
  logic [7:0] set_vec;
  logic [7:0] cond_vec;
  logic [7:0] next_event_flags;
  logic [7:0] next_event_enables;

  assign rd_ev  = cmd_valid && !cmd_write && cmd_op == cisf_pkg::OP_RD_EVENTS;
  assign rd_err = cmd_valid && !cmd_write && cmd_op == cisf_pkg::OP_RD_ERROR;
  assign mode_apply = mode_state == cisf_pkg::CISF_DRAIN && cnd.tx_empty;

  //////////////////////////////////////////////////////////////////////////////
  // event capture

  always_comb begin
    set_vec = 8'h00;
    set_vec[cisf_pkg::EV_RX_STAGING] = ev.rx_staging;
    set_vec[cisf_pkg::EV_RX_ACCEPT]  = ev.rx_accept;
    set_vec[cisf_pkg::EV_TX_DONE]    = ev.tx_done;
    set_vec[cisf_pkg::EV_BUS_FAULT]  = |ev.err_cause;
    set_vec[cisf_pkg::EV_MODE]       = mode_apply;
    set_vec[cisf_pkg::EV_WAKE]       = ev.bus_wake;
    set_vec[cisf_pkg::EV_FILTER1]    = ev.rx_accept && ev.hit_idx == 3'h1;
    set_vec[cisf_pkg::EV_FILTER0]    = ev.rx_accept && ev.hit_idx == 3'h0;
  end

  // a set arriving with the clearing read survives into the next read
  assign next_event_flags = (rd_ev ? 8'h00 : event_flags) | set_vec;

  // an enable written while its flag already stands raises the pin at once
  assign next_event_enables = (cmd_valid && cmd_write && cmd_op == cisf_pkg::OP_WR_EV_EN)
                              ? cmd_wdata : event_enables;

  always_ff @(posedge mclk) begin
    if (srst) begin
      event_flags <= cisf_pkg::EV_FLAGS_RST;
    end else begin
      event_flags <= next_event_flags;
    end
  end

  // pin stays latched even if enables drop; only the read releases it
  always_ff @(posedge mclk) begin
    if (srst) begin
      int_pin <= 1'b0;
    end else begin
      int_pin <= (int_pin && !rd_ev) | (|(next_event_flags & next_event_enables));
    end
  end

  // error cause bits stay until the error register is read
  always_ff @(posedge mclk) begin
    if (srst) begin
      err_cause <= 5'h00;
    end else begin
      err_cause <= (rd_err ? 5'h00 : err_cause) | ev.err_cause;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      filter_match_code <= cisf_pkg::FILT_NONE;
    end else if (ev.rx_accept) begin
      filter_match_code <= {1'b1, ev.hit_idx};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode change waits for the transmit queue to drain

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_state <= cisf_pkg::CISF_RUN;
      pend_mode  <= cisf_pkg::MODE_RST;
      cur_mode   <= cisf_pkg::MODE_RST;
    end else begin
      unique case (mode_state)
        cisf_pkg::CISF_RUN: begin
          if (mode_req_valid) begin
            pend_mode  <= mode_req;
            mode_state <= cisf_pkg::CISF_DRAIN;
          end
        end
        cisf_pkg::CISF_DRAIN: begin
          if (mode_apply) begin
            cur_mode   <= pend_mode;
            mode_state <= cisf_pkg::CISF_RUN;
          end else if (mode_req_valid) begin
            pend_mode <= mode_req;
          end
        end
        default: begin
          mode_state <= cisf_pkg::CISF_RUN;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // condition flags

  always_comb begin
    cond_vec = 8'h00;
    cond_vec[cisf_pkg::CF_TX_EMPTY]  = cnd.tx_empty;
    cond_vec[cisf_pkg::CF_TX_FULL]   = cnd.tx_full;
    cond_vec[cisf_pkg::CF_HIST_FULL] = cnd.hist_full;
    cond_vec[cisf_pkg::CF_ERR_WARN]  = in_warn(cnd.tec) || in_warn(cnd.rec);
    cond_vec[cisf_pkg::CF_ERR_PASS]  = cnd.err_passive;
    cond_vec[cisf_pkg::CF_BUS_OFF]   = cnd.bus_off;
    cond_vec[cisf_pkg::CF_RX_EMPTY]  = cnd.rx_empty;
    cond_vec[cisf_pkg::CF_RX_FULL]   = cnd.rx_full;
  end

  // no read term here: reading leaves these untouched
  always_ff @(posedge mclk) begin
    if (srst) begin
      condition_flags <= cisf_pkg::COND_RST;
    end else begin
      condition_flags <= cond_vec;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      stat_pin <= 1'b0;
    end else begin
      stat_pin <= |(cond_vec & ~condition_flags & condition_flag_enables);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // aux pins

  always_ff @(posedge mclk) begin
    if (srst) begin
      aux_out_pin_a <= 1'b0;
      aux_out_pin_b <= 1'b0;
    end else begin
      aux_out_pin_a <= pick(aux_pin_select[3:0], event_flags, condition_flags);
      aux_out_pin_b <= pick(aux_pin_select[7:4], event_flags, condition_flags);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // opcode access

  always_ff @(posedge mclk) begin
    if (srst) begin
      event_enables          <= cisf_pkg::EV_EN_RST;
      condition_flag_enables <= cisf_pkg::COND_EN_RST;
      aux_pin_select         <= cisf_pkg::AUX_SEL_RST;
    end else if (cmd_valid && cmd_write) begin
      if (cmd_op == cisf_pkg::OP_WR_EV_EN) begin
        event_enables <= cmd_wdata;
      end
      if (cmd_op == cisf_pkg::OP_WR_COND_EN) begin
        condition_flag_enables <= cmd_wdata;
      end
      if (cmd_op == cisf_pkg::OP_WR_AUX_SEL) begin
        aux_pin_select <= cmd_wdata;
      end
    end
  end

  // unknown opcodes answer zero so the host never sees stale data
  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= cmd_valid && !cmd_write;
      if (cmd_valid && !cmd_write) begin
        unique case (cmd_op)
          cisf_pkg::OP_RD_EVENTS:  rsp_rdata <= event_flags;
          cisf_pkg::OP_RD_EV_EN:   rsp_rdata <= event_enables;
          cisf_pkg::OP_RD_COND:    rsp_rdata <= condition_flags;
          cisf_pkg::OP_RD_COND_EN: rsp_rdata <= condition_flag_enables;
          cisf_pkg::OP_RD_AUX_SEL: rsp_rdata <= aux_pin_select;
          cisf_pkg::OP_RD_ERROR:
            rsp_rdata <= {cnd.bus_off, cnd.tec[7], cnd.rec[7], err_cause};
          default:                 rsp_rdata <= 8'h00;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_mode_req;
    mode_state == cisf_pkg::CISF_RUN && mode_req_valid && !cnd.tx_empty;
  endsequence

  sequence s_drain_wait;
    mode_state == cisf_pkg::CISF_DRAIN && !cnd.tx_empty;
  endsequence

  a_int_latch: assert property (
    |(event_flags & event_enables) |-> int_pin)
    else $error("enabled event flag without interrupt pin");

  a_read_clear: assert property (
    rd_ev && set_vec == 8'h00 |=> event_flags == 8'h00 && !int_pin
      && rsp_valid && rsp_rdata == $past(event_flags))
    else $error("event read did not return and clear");

  a_stage_set: assert property (
    ev.rx_staging |=> event_flags[cisf_pkg::EV_RX_STAGING])
    else $error("staging event lost");

  a_filter_one: assert property (
    ev.rx_accept && ev.hit_idx == 3'h1 |=> event_flags[cisf_pkg::EV_FILTER1]
      && event_flags[cisf_pkg::EV_RX_ACCEPT] && filter_match_code == 4'h9)
    else $error("filter one hit not recorded");

  a_mode_hold: assert property (
    s_mode_req ##1 s_drain_wait |=> $stable(cur_mode)
      && !$rose(event_flags[cisf_pkg::EV_MODE]))
    else $error("mode changed before transmit drain");

  a_mode_apply: assert property (
    mode_apply |=> cur_mode == $past(pend_mode) && event_flags[cisf_pkg::EV_MODE]
      && mode_state == cisf_pkg::CISF_RUN)
    else $error("mode change not applied");

  a_warn_band: assert property (
    cnd.tec == 8'h60 || cnd.rec == 8'h7F |=> condition_flags[cisf_pkg::CF_ERR_WARN])
    else $error("error warning flag missing");

  a_cond_read: assert property (
    cmd_valid && !cmd_write && cmd_op == cisf_pkg::OP_RD_COND
      |=> condition_flags == $past(cond_vec) && rsp_rdata == $past(condition_flags))
    else $error("condition flags altered by read");

  a_stat_pulse: assert property (
    stat_pin == |(condition_flags & ~$past(condition_flags)
      & $past(condition_flag_enables)))
    else $error("status pin pulse wrong");

endmodule

// ### tb/cisf_host_model.sv
// cisf_host_model: host side of the opcode access port, one byte per access.
// assumes accesses are taken on the rising edge and reads answer with rsp_valid.
`timescale 1ns/10ps
module cisf_host_model (
  input  wire logic       mclk,
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic [7:0]      cmd_op,
  output logic [7:0]      cmd_wdata,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_rdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_op    = 8'h00;
    cmd_wdata = 8'h00;
  end

  // enable registers are written and read back by opcode
  task automatic wr(input logic [7:0] op, input logic [7:0] data);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_write = 1'b1;
    cmd_op    = op;
    cmd_wdata = data;
    @(negedge mclk);
    cmd_valid = 1'b0;
    // released data shows no stale value
    cmd_wdata = ~data;
  endtask

  task automatic rd(input logic [7:0] op, output logic [7:0] data);
    int n;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_write = 1'b0;
    cmd_op    = op;
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    data = (rsp_valid === 1'b1) ? rsp_rdata : 8'hXX;
  endtask
endmodule

// ### tb/can_interrupt_status_flags_tb_top.sv
// bench for cisf_core: opcode accesses through the host model, events and levels.
// assumes inputs change on the falling edge only.
`timescale 1ns/10ps
module can_interrupt_status_flags_tb_top;
  logic                  mclk;
  logic                  srst;
  logic                  cmd_valid;
  logic                  cmd_write;
  logic [7:0]            cmd_op;
  logic [7:0]            cmd_wdata;
  logic                  rsp_valid;
  logic [7:0]            rsp_rdata;
  cisf_pkg::cisf_event_s ev;
  cisf_pkg::cisf_cond_s  cnd;
  logic                  mode_req_valid;
  logic [2:0]            mode_req;
  logic [2:0]            cur_mode;
  logic [3:0]            filter_match_code;
  logic                  int_pin;
  logic                  stat_pin;
  logic                  aux_out_pin_a;
  logic                  aux_out_pin_b;
  logic [15:0]           all_flags;
  logic [7:0]            wv [4];
  int                    n_mismatch;
  int                    n_compared;

  cisf_core u_dut (.mclk(mclk), .srst(srst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_op(cmd_op), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .ev(ev), .cnd(cnd), .mode_req_valid(mode_req_valid), .mode_req(mode_req),
    .cur_mode(cur_mode), .filter_match_code(filter_match_code), .int_pin(int_pin),
    .stat_pin(stat_pin), .aux_out_pin_a(aux_out_pin_a), .aux_out_pin_b(aux_out_pin_b));
  cisf_host_model u_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_op(cmd_op), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rchk(input logic [7:0] op, input logic [7:0] exp);
    logic [7:0] v;
    u_host.rd(op, v);
    chk($sformatf("read %h", op), v, exp);
  endtask

  task automatic pin(input string what, input logic seen, input logic exp);
    chk(what, {7'h00, seen}, {7'h00, exp});
  endtask

  // warning bit is never driven here: it follows tec and rec only
  task automatic set_cnd(input logic [7:0] p, input logic [7:0] tec, input logic [7:0] rec);
    @(negedge mclk);
    cnd = {p[7], p[6], p[5], p[3], p[2], p[1], p[0], tec, rec};
  endtask

  task automatic fire(input int k);
    @(negedge mclk);
    case (k)
      0: ev = {1'b0, 1'b1, 3'h0, 1'b0, 5'h00, 1'b0};
      1: ev = {1'b0, 1'b1, 3'h1, 1'b0, 5'h00, 1'b0};
      2: ev = {1'b0, 1'b0, 3'h0, 1'b0, 5'h00, 1'b1};
      3: mode_req_valid = 1'b1;
      4: ev = {1'b0, 1'b0, 3'h0, 1'b0, 5'h04, 1'b0};
      5: ev = {1'b0, 1'b0, 3'h0, 1'b1, 5'h00, 1'b0};
      6: ev = {1'b0, 1'b1, 3'h3, 1'b0, 5'h00, 1'b0};
      default: ev = {1'b1, 1'b0, 3'h0, 1'b0, 5'h00, 1'b0};
    endcase
    @(negedge mclk);
    ev = '0;
    mode_req_valid = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge mclk);
    $display("[FAIL] watchdog expired");
    n_mismatch++;
    end_sim();
  end

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    srst = 1'b1;
    ev = '0;
    mode_req_valid = 1'b0;
    mode_req = 3'h3;
    wv = '{8'h5F, 8'h60, 8'h7F, 8'h80};
    cnd = {7'b1000010, 8'h00, 8'h00};
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    rchk(8'hE2, 8'h82);
    rchk(8'hE4, 8'h00);
    rchk(8'hE6, 8'h00);
    rchk(8'hE8, 8'h00);
    fire(5);
    repeat (3) @(negedge mclk);
    pin("int_pin", int_pin, 1'b0);
    // enabling a standing flag raises the pin; dropping the enable keeps it latched
    u_host.wr(8'h1C, 8'h20);
    pin("int_pin", int_pin, 1'b1);
    u_host.wr(8'h1C, 8'h00);
    pin("int_pin", int_pin, 1'b1);
    rchk(8'hDE, 8'h20);
    pin("int_pin", int_pin, 1'b0);
    for (int k = 0; k < 8; k++) begin
      u_host.wr(8'h1C, 8'h01 << k);
      rchk(8'hE4, 8'h01 << k);
      fire(k);
      repeat (3) @(negedge mclk);
      pin("int_pin", int_pin, 1'b1);
      rchk(8'hDE, 8'((k < 2) ? (8'h40 | (8'h01 << k)) : (8'h01 << k)));
      pin("int_pin", int_pin, 1'b0);
      rchk(8'hDE, 8'h00);
      if (k < 2) chk("filter_match_code", {4'h0, filter_match_code}, 8'h08 | 8'(k));
    end
    rchk(8'hDC, 8'h04);
    rchk(8'hDC, 8'h00);
    // mode change must wait until the transmit queue is empty
    set_cnd(8'h02, 8'h00, 8'h00);
    mode_req = 3'h6;
    fire(3);
    repeat (5) @(negedge mclk);
    chk("cur_mode", {5'h00, cur_mode}, 8'h03);
    rchk(8'hDE, 8'h00);
    set_cnd(8'h82, 8'h00, 8'h00);
    repeat (3) @(negedge mclk);
    chk("cur_mode", {5'h00, cur_mode}, 8'h06);
    rchk(8'hDE, 8'h08);
    u_host.wr(8'h1E, 8'h40);
    rchk(8'hE6, 8'h40);
    set_cnd(8'h40, 8'h00, 8'h00);
    @(negedge mclk);
    pin("stat_pin", stat_pin, 1'b1);
    @(negedge mclk);
    pin("stat_pin", stat_pin, 1'b0);
    set_cnd(8'h60, 8'h00, 8'h00);
    @(negedge mclk);
    pin("stat_pin", stat_pin, 1'b0);
    rchk(8'hE2, 8'h60);
    rchk(8'hE2, 8'h60);
    for (int b = 0; b < 8; b++) begin
      if (b != 4) begin
        set_cnd(8'h01 << b, 8'h00, 8'h00);
        rchk(8'hE2, 8'h01 << b);
      end
    end
    for (int i = 0; i < 8; i++) begin
      set_cnd(8'h00, (i < 4) ? wv[i % 4] : 8'h00, (i < 4) ? 8'h00 : wv[i % 4]);
      rchk(8'hE2, (i % 4 == 1 || i % 4 == 2) ? 8'h10 : 8'h00);
    end
    fire(5);
    fire(2);
    set_cnd(8'hA5, 8'h00, 8'h00);
    all_flags = {8'hA5, 8'h24};
    for (int c = 0; c < 16; c++) begin
      u_host.wr(8'h22, {4'(15 - c), 4'(c)});
      repeat (2) @(negedge mclk);
      pin("aux_out_pin_a", aux_out_pin_a, all_flags[c]);
      pin("aux_out_pin_b", aux_out_pin_b, all_flags[15 - c]);
    end
    rchk(8'hE8, 8'h0F);
    // a reset in mid-run brings every written register back to its reset value
    @(negedge mclk);
    srst = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    pin("int_pin", int_pin, 1'b0);
    rchk(8'hE4, 8'h00);
    rchk(8'hE6, 8'h00);
    rchk(8'hE8, 8'h00);
    rchk(8'hDE, 8'h00);
    rchk(8'hE2, 8'hA5);
    end_sim();
  end
endmodule
